//--- core/eebr_slave.v
// Purpose: two-wire memory slave protocol engine with bus-reset recovery
// Assumes: clk_sys 100 MHz, bus clock well below clk_sys/8
// Notes:   memory array is outside; this block reports writes to it
`timescale 1ns/100ps
`default_nettype none
`include "eebr_defines.vh"
module eebr_slave
#(
    parameter         WRITE_CYCLES = `EEBR_WRITE_CYCLES,
    parameter [2:0]   CHIP_SEL     = 3'h0
)
(
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       sclIn,
    input  wire       sdaIn,
    output reg        sdaOe_n,
    output reg        sdaOut,
    output reg        standby,
    output reg        writeBusy,
    output reg        wrCommit,
    output reg [15:0] wrAddr,
    output reg [7:0]  wrData,
    output reg        wrValid,
    output reg        rdReq,
    input  wire [7:0] rdData
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_CTRL = 6'h02;
    localparam [5:0] ST_ADDR = 6'h04;
    localparam [5:0] ST_WDAT = 6'h08;
    localparam [5:0] ST_RDAT = 6'h10;
    localparam [5:0] ST_IGN  = 6'h20;

    wire              sclS;
    wire              sclRise;
    wire              sclFall;
    wire              sdaS;
    wire              sdaRise;
    wire              sdaFall;

    reg  [5:0]        state_ff;
    reg  [3:0]        bitCnt_ff;
    reg  [7:0]        shift_ff;
    reg               addrHi_ff;
    reg               ackPh_ff;
    reg               pend_ff;
    reg               drive_ff;
    reg  [31:0]       wcCnt_ff;

    eebr_line_sync u_sclSync
    (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .lineIn   (sclIn),
        .lineSync (sclS),
        .lineRise (sclRise),
        .lineFall (sclFall)
    );

    eebr_line_sync u_sdaSync
    (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .lineIn   (sdaIn),
        .lineSync (sdaS),
        .lineRise (sdaRise),
        .lineFall (sdaFall)
    );

    // ------------------------------------------------------------
    // bus conditions
    // ------------------------------------------------------------
    // data edges with clock high; while we hold data low none can occur
    wire startCond = sdaFall & sclS & ~drive_ff;
    wire stopCond  = sdaRise & sclS;
    localparam [6:0] DEV_CODE = `EEBR_DEV_CODE_HI;
    // upper four code bits, then the strapped chip address
    wire [6:0] devMatch = {DEV_CODE[6:3], CHIP_SEL};
    wire [7:0] rxByte  = {shift_ff[6:0], sdaS};

    // ------------------------------------------------------------
    // protocol engine
    // ------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state_ff  <= ST_IDLE;
            bitCnt_ff <= 4'h0;
            shift_ff  <= 8'h00;
            addrHi_ff <= 1'b0;
            ackPh_ff  <= 1'b0;
            pend_ff   <= 1'b0;
            drive_ff  <= 1'b0;
            sdaOe_n   <= 1'b1;
            sdaOut    <= 1'b1;
            standby   <= 1'b1;
            writeBusy <= 1'b0;
            wrCommit  <= 1'b0;
            wrAddr    <= 16'h0000;
            wrData    <= 8'h00;
            wrValid   <= 1'b0;
            rdReq     <= 1'b0;
            wcCnt_ff  <= 32'h0;
        end
        else
        begin
            wrValid  <= 1'b0;
            wrCommit <= 1'b0;
            rdReq    <= 1'b0;
            // internal write timer; bus ignored while it runs
            if (writeBusy)
            begin
                if (wcCnt_ff == 32'h1)
                    writeBusy <= 1'b0;
                wcCnt_ff <= wcCnt_ff - 32'h1;
            end
            if (startCond)
            begin
                // abort anything, drop pending write data
                state_ff  <= writeBusy ? ST_IGN : ST_CTRL;
                pend_ff   <= 1'b0;
                bitCnt_ff <= 4'h0;
                ackPh_ff  <= 1'b0;
                standby   <= 1'b0;
                drive_ff  <= 1'b0;
                sdaOe_n   <= 1'b1;
            end
            else if (stopCond)
            begin
                state_ff <= ST_IDLE;
                standby  <= 1'b1;
                drive_ff <= 1'b0;
                sdaOe_n  <= 1'b1;
                if (pend_ff)
                begin
                    wrCommit  <= 1'b1;
                    writeBusy <= 1'b1;
                    wcCnt_ff  <= WRITE_CYCLES;
                    pend_ff   <= 1'b0;
                end
            end
            else if (sclRise && state_ff != ST_IDLE && state_ff != ST_IGN)
            begin
                if (ackPh_ff)
                begin
                    // master's acknowledge slot after our byte
                    if (state_ff == ST_RDAT && sdaS)
                        state_ff <= ST_IGN;
                end
                else
                begin
                    shift_ff  <= rxByte;
                    bitCnt_ff <= bitCnt_ff + 4'h1;
                end
            end
            else if (sclFall && state_ff != ST_IDLE && state_ff != ST_IGN)
            begin
                if (ackPh_ff)
                begin
                    // end of ack slot: release, maybe present data
                    ackPh_ff  <= 1'b0;
                    bitCnt_ff <= 4'h0;
                    drive_ff  <= 1'b0;
                    sdaOe_n   <= 1'b1;
                    if (state_ff == ST_RDAT)
                    begin
                        shift_ff <= rdData;
                        drive_ff <= ~rdData[7];
                        sdaOe_n  <= rdData[7];
                        wrAddr   <= wrAddr + 16'h1;
                    end
                end
                else if (state_ff == ST_RDAT && bitCnt_ff != `EEBR_BITS_PER_BYTE)
                begin
                    // the rise already moved the next bit up, so a
                    // second shift here would skip bits
                    drive_ff <= ~shift_ff[7];
                    sdaOe_n  <= shift_ff[7];
                end
                else if (bitCnt_ff == `EEBR_BITS_PER_BYTE)
                begin
                    ackPh_ff <= 1'b1;
                    drive_ff <= 1'b0;
                    sdaOe_n  <= 1'b1;
                    case (state_ff)
                    ST_CTRL:
                    begin
                        if (shift_ff[7:1] == devMatch)
                        begin
                            drive_ff <= 1'b1;
                            sdaOe_n  <= 1'b0;
                            sdaOut   <= 1'b0;
                            state_ff <= shift_ff[0] ? ST_RDAT : ST_ADDR;
                            addrHi_ff <= 1'b1;
                            if (shift_ff[0])
                                rdReq <= 1'b1;
                        end
                        else
                            state_ff <= ST_IGN;
                    end
                    ST_ADDR:
                    begin
                        drive_ff  <= 1'b1;
                        sdaOe_n   <= 1'b0;
                        sdaOut    <= 1'b0;
                        addrHi_ff <= 1'b0;
                        if (addrHi_ff)
                            wrAddr[15:8] <= shift_ff;
                        else
                        begin
                            wrAddr[7:0] <= shift_ff;
                            state_ff    <= ST_WDAT;
                        end
                    end
                    ST_WDAT:
                    begin
                        // byte buffered, committed only on a later stop
                        drive_ff <= 1'b1;
                        sdaOe_n  <= 1'b0;
                        sdaOut   <= 1'b0;
                        wrData   <= shift_ff;
                        wrValid  <= 1'b1;
                        pend_ff  <= 1'b1;
                    end
                    ST_RDAT:
                    begin
                        rdReq <= 1'b1;
                        ackPh_ff <= 1'b1;
                    end
                    default:
                        state_ff <= ST_IGN;
                    endcase
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- core/eebr_defines.vh
// Purpose: constants for the two-wire memory slave bus front end
// Assumes: plain Verilog-2005, included by bare name
// Notes:   control bytes are seven address bits and one direction bit
`ifndef EEBR_DEFINES_VH
`define EEBR_DEFINES_VH

`define EEBR_BITS_PER_BYTE    4'h8
`define EEBR_ACK_BIT_NUM      4'h8
`define EEBR_DEV_CODE_HI      7'h50
`define EEBR_DEV_CODE_MASK    7'h78
`define EEBR_WRITE_TIME_NS    5000000
`define EEBR_CLK_NS           10
`define EEBR_WRITE_CYCLES     ((`EEBR_WRITE_TIME_NS + `EEBR_CLK_NS - 1) / `EEBR_CLK_NS)

`endif

//--- core/eebr_line_sync.v
// Purpose: two-stage synchroniser with edge detection behind stage two
// Assumes: single clk_sys domain, synchronous active-low reset
// Notes:   stage one is read by stage two only
`timescale 1ns/100ps
`default_nettype none
module eebr_line_sync
(
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       lineIn,
    output reg        lineSync,
    output reg        lineRise,
    output reg        lineFall
);
    reg               meta_ff;
    reg               stage_ff;

    // ------------------------------------------------------------
    // synchroniser
    // ------------------------------------------------------------
    // lines idle high, so reset to one avoids a false fall
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            meta_ff  <= 1'b1;
            stage_ff <= 1'b1;
            lineSync <= 1'b1;
            lineRise <= 1'b0;
            lineFall <= 1'b0;
        end
        else
        begin
            meta_ff  <= lineIn;
            stage_ff <= meta_ff;
            lineSync <= stage_ff;
            lineRise <= stage_ff & ~lineSync;
            lineFall <= ~stage_ff & lineSync;
        end
    end
endmodule
`default_nettype wire

//--- verification/eebr_slave_properties.sv
// Purpose: protocol checks on the memory slave ports
// Assumes: one clk_sys domain, bus pins seen as raw levels
// Notes:   bound to every eebr_slave instance
`timescale 1ns/100ps
`default_nettype none
module eebr_slave_props
#(
    parameter       WRITE_CYCLES = 50,
    parameter [2:0] CHIP_SEL     = 3'h0
)
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        sclIn,
    input wire logic        sdaIn,
    input wire logic        sdaOe_n,
    input wire logic        sdaOut,
    input wire logic        standby,
    input wire logic        writeBusy,
    input wire logic        wrCommit,
    input wire logic [15:0] wrAddr,
    input wire logic [7:0]  wrData,
    input wire logic        wrValid,
    input wire logic        rdReq,
    input wire logic [7:0]  rdData
);
    // ----------------------------------------
    // port relations
    // ----------------------------------------
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    chk_drive_low: assert property (!sdaOe_n |-> !sdaOut)
        else $error("slave drives a high data level");
    chk_commit_pulse: assert property (wrCommit |=> !wrCommit)
        else $error("commit pulse longer than one cycle");
    chk_commit_busy: assert property (wrCommit |-> ##[0:2] writeBusy)
        else $error("commit without write cycle");
    chk_commit_stop: assert property (wrCommit |-> sclIn && sdaIn)
        else $error("commit outside a stop");
    chk_valid_pulse: assert property (wrValid |=> !wrValid)
        else $error("data pulse longer than one cycle");
    chk_standby_idle: assert property (standby |-> sdaOe_n)
        else $error("data driven in standby");
    chk_busy_quiet: assert property (writeBusy |-> sdaOe_n)
        else $error("data driven during write cycle");
    // no drive and no commit right after a start; a slip shows at once
    chk_start_clean: assert property (sclIn && $fell(sdaIn) |->
        (sdaOe_n && !wrCommit) [*6])
        else $error("start did not leave slave quiet");
    chk_stop_idle: assert property (sclIn && $rose(sdaIn) |->
        ##[1:8] (standby || writeBusy))
        else $error("stop did not idle the slave");

    cover property (wrCommit);
    cover property ($rose(standby));
    cover property (rdReq);
endmodule
bind eebr_slave eebr_slave_props
#(.WRITE_CYCLES(WRITE_CYCLES), .CHIP_SEL(CHIP_SEL)) u_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOe_n(sdaOe_n), .sdaOut(sdaOut), .standby(standby),
    .writeBusy(writeBusy), .wrCommit(wrCommit), .wrAddr(wrAddr),
    .wrData(wrData), .wrValid(wrValid), .rdReq(rdReq), .rdData(rdData));
`default_nettype wire

//--- verification/eebr_mst_model.sv
// Purpose: bit-level two-wire bus master facing the slave
// Assumes: open-drain data line with pull-up, clock driven directly, 125 ns bit time
// Notes:   clock rests high between frames, data is only released
`timescale 1ns/100ps
`default_nettype none
module eebr_mst_model
(
    output var logic sclOut,
    output var logic sdaRel,
    input  wire logic sdaLine
);
    localparam real Q = 31.25;
    // ----------------------------------------
    // line sequences
    // ----------------------------------------
    // both lines released at power-up
    initial
    begin
        sclOut = 1'b1;
        sdaRel = 1'b1;
    end
    // data falls while clock is high
    task automatic startC();
        sdaRel = 1'b1;
        #Q sclOut = 1'b1;
        #Q sdaRel = 1'b0;
        #Q sclOut = 1'b0;
        #Q;
    endtask
    task automatic stopC();
        sdaRel = 1'b0;
        #Q sclOut = 1'b1;
        #Q sdaRel = 1'b1;
        #Q;
    endtask
    // a one is released, never driven, so slave zeros win
    task automatic xbits(input logic [8:0] v, input int n,
                         output logic [8:0] r);
        r = 9'h000;
        for (int i = 0; i < n; i++)
        begin
            sdaRel = v[8 - i];
            #Q sclOut = 1'b1;
            #Q r = {r[7:0], sdaLine};
            #Q sclOut = 1'b0;
            #Q;
        end
    endtask
    // start, nine released ones, start, stop, by direct pin control
    task automatic rstSeq();
        logic [8:0] r;
        startC();
        xbits(9'h1FF, 9, r);
        startC();
        stopC();
    endtask
endmodule
`default_nettype wire

//--- verification/eebr_slave_tb_top.sv
// Purpose: directed bench for the slave bus-reset recovery
// Assumes: short write cycle parameter, pull-up on the data line only, clock driven by the master
// Notes:   read data is held constant, enough for the read path
`timescale 1ns/100ps
`default_nettype none
module eebr_slave_tb_top;
    logic       clk_sys = 1'b0;
    logic       rst_n = 1'b0;
    logic       sclBus;
    logic       mstSda;
    logic       sdaOe_n;
    logic       sdaOut;
    logic       standby;
    logic       writeBusy;
    logic       wrCommit;
    logic [7:0] wrData;
    logic [15:0] wrAddr;
    logic       wrValid;
    logic       rdReq;
    logic [7:0] commitCnt = 8'h00;
    logic [7:0] validCnt = 8'h00;
    logic [7:0] rdCnt = 8'h00;
    int         fails = 0;
    int         n_checks = 0;
    // ----------------------------------------
    // clock, wiring, instances
    // ----------------------------------------
    always #5 clk_sys = ~clk_sys;
    // wired-and: pull-up unless some party pulls low
    wire sdaBus = mstSda & (sdaOe_n | sdaOut);
    // pulse counters; a pulse still unknown before reset is not counted
    always @(posedge clk_sys)
    begin
        if (wrCommit === 1'b1)
            commitCnt <= commitCnt + 8'h01;
        if (wrValid === 1'b1)
            validCnt <= validCnt + 8'h01;
        if (rdReq === 1'b1)
            rdCnt <= rdCnt + 8'h01;
    end
    eebr_mst_model u_mst (.sclOut(sclBus), .sdaRel(mstSda),
        .sdaLine(sdaBus));
    eebr_slave #(.WRITE_CYCLES(50)) u_dut (.clk_sys(clk_sys),
        .rst_n(rst_n), .sclIn(sclBus), .sdaIn(sdaBus), .sdaOe_n(sdaOe_n),
        .sdaOut(sdaOut), .standby(standby), .writeBusy(writeBusy),
        .wrCommit(wrCommit), .wrAddr(wrAddr), .wrData(wrData),
        .wrValid(wrValid), .rdReq(rdReq), .rdData(8'h3C));
    // ----------------------------------------
    // helpers and scenarios
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic sendByte(input logic [7:0] d, input logic ack);
        logic [8:0] r;
        u_mst.xbits({d, 1'b1}, 9, r);
        check(8'(r[0]), 8'(ack));
    endtask
    task automatic test_other_dev();
        u_mst.startC();
        sendByte(8'hB0, 1'b1);
        u_mst.stopC();
        settle(10);
        check(8'(standby), 8'h01);
        $display("done other_dev");
    endtask
    task automatic test_read_nack();
        logic [8:0] r;
        logic [7:0] rdBase;
        rdBase = rdCnt;
        u_mst.startC();
        sendByte(8'hA1, 1'b0);
        check(8'(rdCnt != rdBase), 8'h01);
        u_mst.xbits(9'h1FF, 9, r);
        check(r[8:1], 8'h3C);
        settle(10);
        check(8'(sdaOe_n), 8'h01);
        u_mst.stopC();
        settle(10);
        check(8'(standby), 8'h01);
        $display("done read_nack");
    endtask
    task automatic test_write();
        logic [7:0] base;
        logic [7:0] vBase;
        base = commitCnt;
        vBase = validCnt;
        u_mst.startC();
        sendByte(8'hA0, 1'b0);
        sendByte(8'h01, 1'b0);
        sendByte(8'h23, 1'b0);
        sendByte(8'h5A, 1'b0);
        check(wrData, 8'h5A);
        check(validCnt, vBase + 8'h01);
        check(wrAddr[15:8], 8'h01);
        check(wrAddr[7:0], 8'h23);
        u_mst.stopC();
        settle(10);
        check(commitCnt, base + 8'h01);
        check(8'(writeBusy), 8'h01);
        // a start inside the write cycle gets no answer
        u_mst.startC();
        sendByte(8'hA0, 1'b1);
        u_mst.stopC();
        settle(10);
        check(8'(writeBusy), 8'h00);
        check(commitCnt, base + 8'h01);
        check(8'(standby), 8'h01);
        $display("done write");
    endtask
    // controller lost mid-write while the slave acks the data byte
    task automatic test_reset_seq();
        logic [7:0] base;
        logic [8:0] r;
        base = commitCnt;
        u_mst.startC();
        sendByte(8'hA0, 1'b0);
        sendByte(8'h01, 1'b0);
        sendByte(8'h24, 1'b0);
        u_mst.xbits({8'hC3, 1'b1}, 8, r);
        u_mst.rstSeq();
        settle(10);
        check(commitCnt, base);
        check(8'(writeBusy), 8'h00);
        check(8'(sdaOe_n), 8'h01);
        check(8'(standby), 8'h01);
        $display("done reset_seq");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (10) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        settle(4);
        test_other_dev();
        test_read_nack();
        test_write();
        test_reset_seq();
        end_of_test();
    end
    // whole run is near 17 us; a hang stops far later
    initial
    begin
        #200000;
        fails++;
        end_of_test();
    end
endmodule
`default_nettype wire
